// >>> otpct_pkg.sv
// Shared constants and types for the customer trim word access link.
package otpct_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned WORD_W = 24;
    localparam logic [7:0] TRIM_ONE_ADDR = 8'h3E;
    localparam logic [7:0] TRIM_TWO_ADDR = 8'h3F;
    localparam logic [23:0] TRIM_RESET = 24'h000000;

    // Operation code field at the top of each trim word.
    localparam int unsigned OP_MSB = 23;
    localparam int unsigned OP_LSB = 21;
    localparam logic [2:0] OP_STD_READ = 3'h1;
    localparam logic [2:0] OP_MARGIN_READ = 3'h2;
    localparam logic [2:0] OP_BLANK_CHECK = 3'h3;
    localparam logic [2:0] OP_BURN = 3'h4;
    localparam logic [2:0] OP_END_TRIM = 3'h7;

    // Fields of the first trim word.
    localparam int unsigned SETPOINT_MSB = 20;
    localparam int unsigned SETPOINT_LSB = 14;
    localparam int unsigned LIMIT_MSB = 13;
    localparam int unsigned LIMIT_LSB = 12;
    localparam int unsigned FREQ_MSB = 11;
    localparam int unsigned FREQ_LSB = 9;
    localparam int unsigned MOD_MSB = 8;
    localparam int unsigned MOD_LSB = 7;
    localparam int unsigned DEV_MSB = 6;
    localparam int unsigned DEV_LSB = 5;

    // Fields of the second trim word.
    localparam int unsigned PHASE_MSB = 20;
    localparam int unsigned PHASE_LSB = 19;
    localparam int unsigned MS_BIT = 18;
    localparam int unsigned DIS_MSB = 17;
    localparam int unsigned DIS_LSB = 16;
    localparam int unsigned SLOPE_MSB = 15;
    localparam int unsigned SLOPE_LSB = 10;
    localparam int unsigned GAIN_MSB = 9;
    localparam int unsigned GAIN_LSB = 8;
    localparam int unsigned AMP_DIS_BIT = 7;
    localparam int unsigned DITH_BIT = 6;
    localparam int unsigned DONE_BIT = 5;
    localparam int unsigned PAR_BIT = 0;

    // Fuse cells back bits 20 down to 5; bits 4 to 1 are reserved and read zero.
    localparam int unsigned CELL_MSB = 20;
    localparam int unsigned CELL_LSB = 5;
    localparam logic [1:0] LVL_MAX = 2'h3;
    localparam logic [1:0] STD_THRESH = 2'h1;
    localparam logic [1:0] MARGIN_THRESH = 2'h2;
    localparam logic [1:0] BLANK_THRESH = 2'h1;
    localparam logic [1:0] MAX_BURNS = 2'h3;

    // Host controller registers on AHB-Lite, byte offsets.
    localparam logic [3:0] HOST_CMD_OFF = 4'h0;
    localparam logic [3:0] HOST_WDATA_OFF = 4'h4;
    localparam logic [3:0] HOST_STATUS_OFF = 4'h8;
    localparam logic [3:0] HOST_RDATA_OFF = 4'hC;
    localparam int unsigned CMD_WRITE_BIT = 8;
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_REFUSED = 1;
    localparam int unsigned STAT_SEQ_ERR = 2;
    localparam int unsigned STAT_BLANK_FIRST = 3;
    localparam int unsigned STAT_BURN_LSB = 4;
    localparam int unsigned STAT_MARGIN_OK = 6;
    localparam int unsigned STAT_FINAL_BLANK = 7;

    typedef enum logic [1:0] {
        LNK_IDLE = 2'b00,
        LNK_REQ = 2'b01,
        LNK_FIN = 2'b11
    } otpct_link_state_type;

endpackage

// >>> otpct_if.sv
// Word-level link between the trim host controller and the trim access logic.
`timescale 1ns/1ns
interface otpct_if;
    logic req;
    logic write;
    logic [7:0] addr;
    logic [23:0] wdata;
    logic ack;
    logic refused;
    logic [23:0] rdata;

    modport dev (
        input req,
        input write,
        input addr,
        input wdata,
        output ack,
        output refused,
        output rdata
    );

    modport host (
        output req,
        output write,
        output addr,
        output wdata,
        input ack,
        input refused,
        input rdata
    );
endinterface

// >>> otpct_parity.sv
// Odd parity bit generator over bits 23 down to 1 of a trim word.
`timescale 1ns/1ns
module otpct_parity (
    input wire logic [23:1] data,
    output logic par
);
    // The bit makes the count of ones over the whole word odd.
    assign par = ~(^data);
endmodule

// >>> otpct_device.sv
// Trim word access logic: two trim registers, fuse cell array and opcode handling.
// Notes on behaviour
// - Opcode field selects read, margin, blank, burn, end.
// - Access only in normal state, not after end.
// - First word field layout, reserved bits zero.
// - Second word field layout with end flag.
// - Sender puts odd parity in bit zero.
// - Unwritten cell reads zero, written reads one.
// - Blank check reads every cell of both words.
// - Margin read uses a stricter written threshold.
// - Host starts with a blank check.
// - Host loads bits, then issues burn.
// - Host burns at most three times.
// - Host verifies with a margin read.
// - Host finishes with another blank check.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module otpct_device (
    input wire logic hclk,
    input wire logic hresetn,
    otpct_if.dev link,
    input wire logic normal_operating_state,
    output logic trim_final,
    output logic [6:0] default_output_setpoint,
    output logic [1:0] default_current_limit,
    output logic [2:0] default_switch_frequency,
    output logic [1:0] default_dither_modulation,
    output logic [1:0] default_dither_deviation,
    output logic [1:0] default_phase_count,
    output logic default_master_slave,
    output logic [1:0] default_converter_disable,
    output logic [5:0] default_slope_control,
    output logic [1:0] default_amp_gain,
    output logic default_amp_disable,
    output logic default_dither_enable,
    output logic trim_done_flag
);

    typedef logic [otpct_pkg::CELL_MSB:otpct_pkg::CELL_LSB][1:0] otpct_cells_type;

    typedef struct packed {
        logic [2:0] mode_sync;
        logic mode_ok;
        logic [1:0][23:0] word;
        otpct_cells_type [1:0] cells;
        logic done;
        logic ack;
        logic refused;
        logic [23:0] rdata;
    } otpct_dev_state_type;

    otpct_dev_state_type cur_ff;
    otpct_dev_state_type nxt_cur;
    logic wr_par;
    logic rd_par;
    logic [23:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Cell sensing: a cell reads one once its burn level reaches the threshold.

    // Sense every cell of one word against a threshold, giving word bit positions.
    function automatic logic [23:0] sense_word(input otpct_cells_type cells, input logic [1:0] thresh);
        logic [23:0] bits;
        bits = otpct_pkg::TRIM_RESET;
        for (int i = otpct_pkg::CELL_LSB; i <= otpct_pkg::CELL_MSB; i++) begin
            bits[i] = (cells[i] >= thresh);
        end
        return bits;
    endfunction

    // Field bits kept by a register load; reserved bits and the parity bit stay zero.
    function automatic logic [23:0] field_bits(input logic [23:0] w);
        logic [23:0] f;
        f = otpct_pkg::TRIM_RESET;
        f[otpct_pkg::CELL_MSB:otpct_pkg::CELL_LSB] = w[otpct_pkg::CELL_MSB:otpct_pkg::CELL_LSB];
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Parity: check of the incoming word and generation for the outgoing one.

    otpct_parity u_wr_par (
        .data(link.wdata[23:1]),
        .par(wr_par)
    );

    // Read data shows the addressed register with a fresh parity bit.
    assign rd_word = (link.addr == otpct_pkg::TRIM_TWO_ADDR) ? cur_ff.word[1] : cur_ff.word[0];

    otpct_parity u_rd_par (
        .data(rd_word[23:1]),
        .par(rd_par)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    // A request is served once: the answer pulse lands one cycle after req rises and
    // the host drops req on it, so a held req never runs an operation twice.
    always_comb begin
        logic sel;
        logic hit;
        logic granted;
        logic [2:0] op;
        logic [23:0] bits;
        logic [23:0] done_bits;
        sel = 1'b0;
        hit = 1'b0;
        granted = 1'b0;
        op = link.wdata[otpct_pkg::OP_MSB:otpct_pkg::OP_LSB];
        bits = otpct_pkg::TRIM_RESET;
        done_bits = sense_word(cur_ff.cells[1], otpct_pkg::STD_THRESH);
        nxt_cur = cur_ff;
        nxt_cur.ack = 1'b0;
        nxt_cur.refused = 1'b0;

        // The mode pin is taken only once the second and third stages agree.
        nxt_cur.mode_sync = {cur_ff.mode_sync[1:0], normal_operating_state};
        if (cur_ff.mode_sync[1] == cur_ff.mode_sync[2]) begin
            nxt_cur.mode_ok = cur_ff.mode_sync[2];
        end

        // An end flag found in a register or burned into its cell makes the trim final.
        if (cur_ff.word[1][otpct_pkg::DONE_BIT] || done_bits[otpct_pkg::DONE_BIT]) begin
            nxt_cur.done = 1'b1;
        end

        hit = (link.addr == otpct_pkg::TRIM_ONE_ADDR) || (link.addr == otpct_pkg::TRIM_TWO_ADDR);
        sel = (link.addr == otpct_pkg::TRIM_TWO_ADDR);
        granted = cur_ff.mode_ok && !cur_ff.done && hit;

        if (link.req && !cur_ff.ack) begin
            nxt_cur.ack = 1'b1;
            nxt_cur.rdata = otpct_pkg::TRIM_RESET;
            if (!granted) begin
                nxt_cur.refused = 1'b1;
            end else if (!link.write) begin
                nxt_cur.rdata = {rd_word[23:1], rd_par};
            end else if (link.wdata[otpct_pkg::PAR_BIT] != wr_par) begin
                // A corrupted word must not start a burn, so it changes nothing.
                nxt_cur.refused = 1'b1;
            end else begin
                nxt_cur.word[sel][otpct_pkg::OP_MSB:otpct_pkg::OP_LSB] = op;
                case (op)
                    otpct_pkg::OP_STD_READ: begin
                        bits = sense_word(cur_ff.cells[sel], otpct_pkg::STD_THRESH);
                        nxt_cur.word[sel] = {op, bits[20:0]};
                    end
                    otpct_pkg::OP_MARGIN_READ: begin
                        bits = sense_word(cur_ff.cells[sel], otpct_pkg::MARGIN_THRESH);
                        nxt_cur.word[sel] = {op, bits[20:0]};
                    end
                    otpct_pkg::OP_BLANK_CHECK: begin
                        // Both words are sensed so that every cell is covered at once.
                        for (int w = 0; w < 2; w++) begin
                            bits = sense_word(cur_ff.cells[w], otpct_pkg::BLANK_THRESH);
                            nxt_cur.word[w] = {op, bits[20:0]};
                        end
                    end
                    otpct_pkg::OP_BURN: begin
                        bits = field_bits(link.wdata);
                        nxt_cur.word[sel] = {op, bits[20:0]};
                        // Each burn strengthens the selected cells; the level saturates.
                        for (int i = otpct_pkg::CELL_LSB; i <= otpct_pkg::CELL_MSB; i++) begin
                            if (bits[i] && cur_ff.cells[sel][i] != otpct_pkg::LVL_MAX) begin
                                nxt_cur.cells[sel][i] = cur_ff.cells[sel][i] + 2'h1;
                            end
                        end
                    end
                    otpct_pkg::OP_END_TRIM: begin
                        nxt_cur.done = 1'b1;
                    end
                    default: begin
                        nxt_cur.word[sel][otpct_pkg::OP_MSB:otpct_pkg::OP_LSB] = op;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // The fuse levels reset with the logic; a real array keeps them through power down.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops.

    // Link answer.
    assign link.ack = cur_ff.ack;
    assign link.refused = cur_ff.refused;
    assign link.rdata = cur_ff.rdata;

    // Trim defaults as held in the two registers.
    assign trim_final = cur_ff.done;
    assign default_output_setpoint = cur_ff.word[0][otpct_pkg::SETPOINT_MSB:otpct_pkg::SETPOINT_LSB];
    assign default_current_limit = cur_ff.word[0][otpct_pkg::LIMIT_MSB:otpct_pkg::LIMIT_LSB];
    assign default_switch_frequency = cur_ff.word[0][otpct_pkg::FREQ_MSB:otpct_pkg::FREQ_LSB];
    assign default_dither_modulation = cur_ff.word[0][otpct_pkg::MOD_MSB:otpct_pkg::MOD_LSB];
    assign default_dither_deviation = cur_ff.word[0][otpct_pkg::DEV_MSB:otpct_pkg::DEV_LSB];
    assign default_phase_count = cur_ff.word[1][otpct_pkg::PHASE_MSB:otpct_pkg::PHASE_LSB];
    assign default_master_slave = cur_ff.word[1][otpct_pkg::MS_BIT];
    assign default_converter_disable = cur_ff.word[1][otpct_pkg::DIS_MSB:otpct_pkg::DIS_LSB];
    assign default_slope_control = cur_ff.word[1][otpct_pkg::SLOPE_MSB:otpct_pkg::SLOPE_LSB];
    assign default_amp_gain = cur_ff.word[1][otpct_pkg::GAIN_MSB:otpct_pkg::GAIN_LSB];
    assign default_amp_disable = cur_ff.word[1][otpct_pkg::AMP_DIS_BIT];
    assign default_dither_enable = cur_ff.word[1][otpct_pkg::DITH_BIT];
    assign trim_done_flag = cur_ff.word[1][otpct_pkg::DONE_BIT];

endmodule

// >>> otpct_host.sv
// Trim host controller: AHB-Lite registers, sequence guard and link master.
`timescale 1ns/1ns
module otpct_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    otpct_if.host link
);

    typedef otpct_pkg::otpct_link_state_type otpct_link_state_type;

    typedef struct packed {
        otpct_link_state_type state;
        logic a_wr;
        logic a_rd;
        logic [3:0] a_off;
        logic [7:0] cmd_addr;
        logic cmd_write;
        logic [23:0] wdata;
        logic [23:0] rdata;
        logic [31:0] hrdata;
        logic refused;
        logic seq_err;
        logic blank_first;
        logic [1:0] burns;
        logic margin_ok;
        logic final_blank;
    } otpct_host_state_type;

    otpct_host_state_type cur_ff;
    otpct_host_state_type nxt_cur;
    logic par;
    logic [31:0] status;

    ////////////////////////////////////////////////////////////////////////////////
    // The sender puts odd parity on every word it drives out.

    otpct_parity u_par (
        .data(cur_ff.wdata[23:1]),
        .par(par)
    );

    // Status word for software.
    always_comb begin
        status = 32'h00000000;
        status[otpct_pkg::STAT_BUSY] = (cur_ff.state != otpct_pkg::LNK_IDLE);
        status[otpct_pkg::STAT_REFUSED] = cur_ff.refused;
        status[otpct_pkg::STAT_SEQ_ERR] = cur_ff.seq_err;
        status[otpct_pkg::STAT_BLANK_FIRST] = cur_ff.blank_first;
        status[otpct_pkg::STAT_BURN_LSB +: 2] = cur_ff.burns;
        status[otpct_pkg::STAT_MARGIN_OK] = cur_ff.margin_ok;
        status[otpct_pkg::STAT_FINAL_BLANK] = cur_ff.final_blank;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: bus slave, command start and link sequencing.

    always_comb begin
        logic [2:0] op;
        logic start;
        op = cur_ff.wdata[otpct_pkg::OP_MSB:otpct_pkg::OP_LSB];
        start = 1'b0;
        nxt_cur = cur_ff;

        // Address phase: note the access and prepare read data for the data phase.
        nxt_cur.a_wr = hsel && htrans[1] && hready && hwrite;
        nxt_cur.a_rd = hsel && htrans[1] && hready && !hwrite;
        nxt_cur.a_off = haddr[3:0];
        case (haddr[3:0])
            otpct_pkg::HOST_CMD_OFF: nxt_cur.hrdata = {23'h000000, cur_ff.cmd_write, cur_ff.cmd_addr};
            otpct_pkg::HOST_WDATA_OFF: nxt_cur.hrdata = {8'h00, cur_ff.wdata};
            otpct_pkg::HOST_STATUS_OFF: nxt_cur.hrdata = status;
            otpct_pkg::HOST_RDATA_OFF: nxt_cur.hrdata = {8'h00, cur_ff.rdata};
            default: nxt_cur.hrdata = 32'h00000000;
        endcase

        // Data phase writes; a command write starts a link transfer when idle.
        if (cur_ff.a_wr) begin
            case (cur_ff.a_off)
                otpct_pkg::HOST_CMD_OFF: begin
                    if (cur_ff.state == otpct_pkg::LNK_IDLE) begin
                        nxt_cur.cmd_addr = hwdata[7:0];
                        nxt_cur.cmd_write = hwdata[otpct_pkg::CMD_WRITE_BIT];
                        start = 1'b1;
                    end
                end
                otpct_pkg::HOST_WDATA_OFF: begin
                    if (cur_ff.state == otpct_pkg::LNK_IDLE) begin
                        nxt_cur.wdata = {hwdata[23:1], 1'b0};
                    end
                end
                default: begin
                    nxt_cur.wdata = cur_ff.wdata;
                end
            endcase
        end

        case (cur_ff.state)
            otpct_pkg::LNK_IDLE: begin
                if (start) begin
                    nxt_cur.seq_err = 1'b0;
                    nxt_cur.refused = 1'b0;
                    // A burn is held back before the first blank check or after three burns.
                    if (hwdata[otpct_pkg::CMD_WRITE_BIT] && op == otpct_pkg::OP_BURN &&
                        (!cur_ff.blank_first || cur_ff.burns == otpct_pkg::MAX_BURNS)) begin
                        nxt_cur.seq_err = 1'b1;
                    end else begin
                        nxt_cur.state = otpct_pkg::LNK_REQ;
                    end
                end
            end
            otpct_pkg::LNK_REQ: begin
                if (link.ack) begin
                    nxt_cur.state = otpct_pkg::LNK_FIN;
                    nxt_cur.refused = link.refused;
                    nxt_cur.rdata = link.rdata;
                    if (!link.refused && cur_ff.cmd_write) begin
                        if (op == otpct_pkg::OP_BLANK_CHECK && cur_ff.burns == 2'h0) begin
                            nxt_cur.blank_first = 1'b1;
                        end
                        if (op == otpct_pkg::OP_BLANK_CHECK && cur_ff.margin_ok) begin
                            nxt_cur.final_blank = 1'b1;
                        end
                        if (op == otpct_pkg::OP_BURN) begin
                            nxt_cur.burns = cur_ff.burns + 2'h1;
                        end
                        if (op == otpct_pkg::OP_MARGIN_READ && cur_ff.burns != 2'h0) begin
                            nxt_cur.margin_ok = 1'b1;
                        end
                    end
                end
            end
            otpct_pkg::LNK_FIN: begin
                nxt_cur.state = otpct_pkg::LNK_IDLE;
            end
            default: begin
                nxt_cur.state = otpct_pkg::LNK_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Zero wait states keep the slave simple; every access answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = cur_ff.hrdata;
    assign link.req = (cur_ff.state == otpct_pkg::LNK_REQ);
    assign link.write = cur_ff.cmd_write;
    assign link.addr = cur_ff.cmd_addr;
    assign link.wdata = {cur_ff.wdata[23:1], par};

endmodule

// >>> otpct_link_sva.sv
// Protocol checker for the trim word link between the host controller and the access logic.
`timescale 1ns/1ns
module otpct_link_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire logic write,
    input wire logic [7:0] addr,
    input wire logic [23:0] wdata,
    input wire logic ack,
    input wire logic refused,
    input wire logic [23:0] rdata
);
    // Both ends share one clock, so one default clocking serves every check.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////////
    ack_after_req_a: assert property ($rose(req) |=> ack) else $error("ack missing after request");
    ack_one_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    refused_with_ack_a: assert property (refused |-> ack) else $error("refused without ack");
    read_parity_a: assert property (ack && !refused && !write |-> ^rdata) else $error("read parity even");
    reserved_zero_a: assert property (ack && !refused && !write |-> rdata[4:1] == 4'h0)
        else $error("reserved bits set");
    quiet_data_a: assert property (ack && (refused || write) |-> rdata == 24'h000000)
        else $error("data on refused or write");
    send_parity_a: assert property (req && write |-> ^wdata) else $error("sent word parity even");
    req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata) && $stable(write))
        else $error("request changed before ack");
    req_release_a: assert property (ack |=> !req [*2]) else $error("request spacing too short");
endmodule

// >>> otp_customer_trim_access_tb.sv
// Bench joining host controller and trim access logic, driven over AHB-Lite.
`timescale 1ns/1ns
module otp_customer_trim_access_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, normal_operating_state, trim_final, trim_done_flag;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, sw;
    logic [6:0] default_output_setpoint;
    int err_count, check_count;
    localparam logic [15:0] FLD = {7'h55, 2'h2, 3'h5, 2'h1, 2'h3};
    otpct_if link();

    // Free running bus clock of 8 ns.
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    otpct_host i_otpct_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .link(link));
    otpct_device i_otpct_device (.hclk(hclk), .hresetn(hresetn), .link(link),
        .normal_operating_state(normal_operating_state), .trim_final(trim_final),
        .default_output_setpoint(default_output_setpoint), .default_current_limit(),
        .default_switch_frequency(), .default_dither_modulation(), .default_dither_deviation(),
        .default_phase_count(), .default_master_slave(), .default_converter_disable(),
        .default_slope_control(), .default_amp_gain(), .default_amp_disable(), .default_dither_enable(),
        .trim_done_flag(trim_done_flag));
    otpct_link_sva i_otpct_link_sva (.hclk(hclk), .hresetn(hresetn), .req(link.req), .write(link.write),
        .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .refused(link.refused), .rdata(link.rdata));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Expected trim word; the bench works parity out itself rather than trusting the design.
    function automatic logic [23:0] tw(input logic [2:0] op, input logic [15:0] f);
        logic [23:0] v;
        v = {op, f, 5'h00};
        v[0] = ~^v[23:1];
        return v;
    endfunction

    // One single AHB transfer; entered just after a rising edge, read data kept in rd.
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // One link transfer: load word, start, wait out busy under a bound, fetch status and read data.
    task automatic link_op(input logic [7:0] a, input logic w, input logic [23:0] word);
        int n;
        bus(32'h4, 1'b1, {8'h00, word});
        bus(32'h0, 1'b1, {23'h0, w, a});
        repeat (4) @(posedge hclk);
        n = 0;
        do begin
            bus(32'h8, 1'b0, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 50);
        check("busy", 32'h0, 32'(rd[0]));
        sw = rd;
        bus(32'hC, 1'b0, 32'h0);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        bus(32'h8, 1'b0, 32'h0);
        check("status", 32'h0, rd);
        check("setpoint", 32'h0, 32'(default_output_setpoint));
        check("done flag", 32'h0, 32'(trim_done_flag));
    endtask

    // Full trim flow: guarded burn, blank, burns with margin verify, fourth burn, final blank.
    task automatic t_flow;
        link_op(8'h3E, 1'b1, {otpct_pkg::OP_BURN, FLD, 5'h0});
        check("early burn", 32'h1, 32'(sw[2]));
        link_op(8'h3E, 1'b1, {otpct_pkg::OP_BLANK_CHECK, 21'h0});
        check("blank first", 32'h1, 32'(sw[3]));
        link_op(8'h3E, 1'b0, 24'h0);
        check("blank word", 32'(tw(otpct_pkg::OP_BLANK_CHECK, 16'h0)), rd);
        link_op(8'h3E, 1'b1, {otpct_pkg::OP_BURN, FLD, 5'h0});
        check("burn count", 32'h1, 32'(sw[5:4]));
        check("setpoint", 32'h55, 32'(default_output_setpoint));
        link_op(8'h3E, 1'b1, {otpct_pkg::OP_MARGIN_READ, 21'h0});
        link_op(8'h3E, 1'b0, 24'h0);
        check("weak margin", 32'(tw(otpct_pkg::OP_MARGIN_READ, 16'h0)), rd);
        repeat (2) link_op(8'h3E, 1'b1, {otpct_pkg::OP_BURN, FLD, 5'h0});
        check("burn count", 32'h3, 32'(sw[5:4]));
        link_op(8'h3E, 1'b1, {otpct_pkg::OP_MARGIN_READ, 21'h0});
        check("margin done", 32'h1, 32'(sw[6]));
        link_op(8'h3E, 1'b0, 24'h0);
        check("margin word", 32'(tw(otpct_pkg::OP_MARGIN_READ, FLD)), rd);
        link_op(8'h3E, 1'b1, {otpct_pkg::OP_BURN, FLD, 5'h0});
        check("fourth burn", 32'h1, 32'(sw[2]));
        link_op(8'h3E, 1'b1, {otpct_pkg::OP_STD_READ, 21'h0});
        link_op(8'h3E, 1'b0, 24'h0);
        check("std word", 32'(tw(otpct_pkg::OP_STD_READ, FLD)), rd);
        link_op(8'h3F, 1'b1, {otpct_pkg::OP_BLANK_CHECK, 21'h0});
        check("final blank", 32'h1, 32'(sw[7]));
    endtask

    // Access outside the normal state is refused, then served again once it returns.
    task automatic t_refuse;
        normal_operating_state <= 1'b0;
        repeat (6) @(posedge hclk);
        link_op(8'h3F, 1'b0, 24'h0);
        check("not normal", 32'h1, 32'(sw[1]));
        normal_operating_state <= 1'b1;
        repeat (6) @(posedge hclk);
        link_op(8'h3F, 1'b0, 24'h0);
        check("normal", 32'h0, 32'(sw[1]));
    endtask

    task automatic t_end;
        link_op(8'h3F, 1'b1, {otpct_pkg::OP_END_TRIM, 21'h0});
        repeat (2) @(posedge hclk);
        check("final", 32'h1, 32'(trim_final));
        link_op(8'h3F, 1'b1, {otpct_pkg::OP_BURN, FLD, 5'h0});
        check("late burn", 32'h1, 32'(sw[1] | sw[2]));
        // Only the device can refuse this one, so it proves the final state holds.
        link_op(8'h3E, 1'b0, 24'h0);
        check("final read", 32'h1, 32'(sw[1]));
    endtask

    // Main sequence: three cycles of reset, settle the state pin, then the scenarios.
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        normal_operating_state = 1'b0;
        err_count = 0;
        check_count = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        normal_operating_state <= 1'b1;
        repeat (6) @(posedge hclk);
        t_reset();
        t_flow();
        t_refuse();
        t_end();
        report_and_stop();
    end

    // Watchdog sized well beyond the few hundred cycles the scenarios need.
    initial begin
        #400000;
        err_count++;
        $display("ERROR watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule
